/* File: src/board_glue_decoder.sv */
// board glue: clock division, memory select, dram strobes and i/o decode
//
// Functional notes
// [RULE1] one binary counter divides the oscillator into half, quarter, eighth rates
// [RULE2] quarter rate clocks the processor, counter-timer and dual serial device
// [RULE3] half rate is the floppy controller master clock
// [RULE4] interrupt enables chain peripheral to peripheral; devices act only when enabled
// [RULE5] dram strobes come from quarter and half clocks, qualified by refresh
// [RULE6] processor supplies refresh addresses and timing; no refresh counter here
// [RULE7] memory access below 32K with latch bit 6 low selects eprom, else ram
// [RULE8] eprom selection triggers a wait state generator for slow eproms
// [RULE9] group 0000 0x decodes control, printer data, strobe set, strobe clear
// [RULE10] strobe-set port sets printer strobe, strobe-clear port clears it
// [RULE11] 0010 0xxx selects scsi controller, low three bits pick register
// [RULE12] 0010 1xx0 asserts scsi dma acknowledge for programmed transfers
// [RULE13] reads at 0010 1xx1 enable the jumper id buffer; input only
// [RULE14] 01xx xxxx selects counter-timer; address bits 5:4 pick channel
// [RULE15] 10xx xxxx selects the dual serial device
// [RULE16] 11xx xxxx selects the floppy controller
// [RULE17] unused groups produce no on-board select
// [RULE18] don't-care bits are ignored so devices alias within their group
// [RULE19] reset clears all board control latch bits, mapping the eprom in
// [RULE20] eprom enable bit high unmaps eprom, leaving all ram
// [RULE21] ram gets no wait states, eprom exactly one
// [RULE22] i/o selects only during i/o read or write, not memory or acknowledge
// [RULE23] all divided clocks come from one counter, phase aligned
`timescale 1ns/10ps
module board_glue_decoder
  import glue_pkg::*;
(
  input wire logic CORE_CLK_I,         // 40 MHz core clock
  input wire logic RSTN_I,             // async reset, active low
  input wire logic CE_I,               // clock enable, freezes state when low
  input wire logic OSC_16M_I,          // 16 MHz oscillator, sampled
  input wire logic [15:0] ADDR_I,      // processor address bus
  input wire logic [7:0] DATA_I,       // processor data bus in
  input wire logic MREQ_N_I,           // memory request, active low
  input wire logic IORQ_N_I,           // i/o request, active low
  input wire logic RD_N_I,             // read strobe, active low
  input wire logic WR_N_I,             // write strobe, active low
  input wire logic M1_N_I,             // opcode fetch / acknowledge, active low
  input wire logic RFSH_N_I,           // refresh cycle, active low
  input wire logic [7:0] JUMPER_ID_I,  // jumper id inputs
  input wire logic COUNTER_TIMER_IEO_I, // counter-timer interrupt enable out
  input wire logic SERIAL_IEO_I,       // serial device interrupt enable out
  output logic CLK_8M_O,               // half rate clock, floppy master clock
  output logic CLK_4M_O,               // quarter rate clock, cpu and peripherals
  output logic CLK_2M_O,               // eighth rate clock
  output logic [7:0] DATA_O,           // data bus drive for id reads
  output logic DATA_OE_O,              // data bus output enable, high drives
  output logic EPROM_SEL_N_O,          // eprom select, active low
  output logic RAM_SEL_N_O,            // ram select, active low
  output logic WAIT_N_O,               // processor wait, active low
  output logic RAS_N_O,                // dram row strobe, active low
  output logic CAS_N_O,                // dram column strobe, active low
  output logic ADDR_MUX_O,             // dram address mux, high = column
  output logic [7:0] BOARD_CTRL_O,     // board control latch outputs
  output logic [7:0] PRINTER_DATA_O,   // printer data latch
  output logic PRINTER_STROBE_O,       // printer data strobe flip-flop
  output logic SCSI_CS_N_O,            // scsi controller select, active low
  output logic SCSI_DACK_N_O,          // scsi dma acknowledge, active low
  output logic [2:0] SCSI_REG_O,       // scsi register index
  output logic ID_OE_N_O,              // id buffer enable, active low
  output logic COUNTER_TIMER_SEL_N_O,  // counter-timer select, active low
  output logic [1:0] COUNTER_TIMER_CHAN_O, // counter-timer channel
  output logic SERIAL_SEL_N_O,         // dual serial select, active low
  output logic FLOPPY_SEL_N_O,         // floppy controller select, active low
  output logic COUNTER_TIMER_IEI_O,    // counter-timer interrupt enable in
  output logic SERIAL_IEI_O,           // serial device interrupt enable in
  output logic EXP_IEI_O               // enable passed on to expansion bus
);

  logic osc_q_ff;
  logic osc_tick;
  logic [DIV_WIDTH-1:0] div_count;
  logic io_cycle;
  logic io_rd;
  logic io_wr;
  logic io_wr_q_ff;
  logic io_wr_edge;
  logic mem_cycle;
  logic rfsh_cycle;
  logic rom_hit;
  logic ram_acc;
  logic [7:0] io_addr;
  logic hit_local;
  logic hit_scsi_cs;
  logic hit_scsi_dack;
  logic hit_id;
  logic hit_counter_timer;
  logic hit_serial;
  logic hit_floppy;
  logic [7:0] board_ctrl_ff;
  logic [7:0] printer_data_ff;
  logic printer_strobe_ff;
  wait_state_t ws_ff;
  wait_state_t nxt_ws;
  logic [3:0] ws_cnt_ff;
  logic [3:0] nxt_ws_cnt;
  logic wait_n_ff;
  logic nxt_wait_n;

  // oscillator edge becomes a one-cycle tick for the divider
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      osc_q_ff <= 1'b0;
    end else if (CE_I) begin
      osc_q_ff <= OSC_16M_I;
    end
  end
  assign osc_tick = OSC_16M_I && !osc_q_ff;

  // single divide counter for all three clocks
  stage_counter #(
    .WIDTH(DIV_WIDTH)
  ) u_div (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RSTN_I),
    .ce_i(CE_I),
    .tick_i(osc_tick),
    .count_o(div_count)
  ); // [RULE1] [RULE23]

  // clock outputs straight from the counter stages
  assign CLK_8M_O = div_count[DIV_HALF_BIT];     // [RULE3]
  assign CLK_4M_O = div_count[DIV_QUARTER_BIT];  // [RULE2]
  assign CLK_2M_O = div_count[DIV_EIGHTH_BIT];   // [RULE1]

  // bus cycle classification
  assign io_cycle = !IORQ_N_I && M1_N_I;          // excludes acknowledge [RULE22]
  assign io_rd = io_cycle && !RD_N_I;
  assign io_wr = io_cycle && !WR_N_I;
  assign io_wr_edge = io_wr && !io_wr_q_ff;
  assign mem_cycle = !MREQ_N_I && RFSH_N_I && (!RD_N_I || !WR_N_I);
  assign rfsh_cycle = !MREQ_N_I && !RFSH_N_I;    // processor-timed refresh [RULE6]
  assign rom_hit = mem_cycle && !ADDR_I[ROM_ADDR_BIT]
                   && !board_ctrl_ff[EPROM_EN_BIT]; // [RULE7] [RULE20]
  assign ram_acc = mem_cycle && !rom_hit;

  // address group decode on the low byte, don't-care bits masked
  assign io_addr = ADDR_I[7:0];
  assign hit_local = (io_addr & LOCAL_MASK & ~8'h03) == 8'h00;           // [RULE9] [RULE18]
  assign hit_scsi_cs = (io_addr & SCSI_CS_MASK) == SCSI_CS_VAL;          // [RULE11]
  assign hit_scsi_dack = (io_addr & SCSI_PORT_MASK) == SCSI_DACK_VAL;    // [RULE12]
  assign hit_id = (io_addr & SCSI_PORT_MASK) == JUMPER_ID_INPUT_OFS;     // [RULE13]
  assign hit_counter_timer = (io_addr & GROUP_MASK) == COUNTER_TIMER_VAL; // [RULE14]
  assign hit_serial = (io_addr & GROUP_MASK) == DUAL_SERIAL_VAL;         // [RULE15]
  assign hit_floppy = (io_addr & GROUP_MASK) == FLOPPY_VAL;              // [RULE16]

  // write edge detect so each output cycle acts once
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      io_wr_q_ff <= 1'b0;
    end else if (CE_I) begin
      io_wr_q_ff <= io_wr;
    end
  end

  // board control latch, cleared by reset
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      board_ctrl_ff <= BOARD_CONTROL_RESET; // [RULE19]
    end else if (CE_I && io_wr_edge && hit_local
                 && (io_addr[1:0] == BOARD_CONTROL_LATCH_OFS[1:0])) begin
      board_ctrl_ff <= DATA_I; // [RULE9]
    end
  end
  assign BOARD_CTRL_O = board_ctrl_ff;

  // printer data latch
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      printer_data_ff <= PRINTER_DATA_RESET;
    end else if (CE_I && io_wr_edge && hit_local
                 && (io_addr[1:0] == PRINTER_DATA_LATCH_OFS[1:0])) begin
      printer_data_ff <= DATA_I; // [RULE9]
    end
  end
  assign PRINTER_DATA_O = printer_data_ff;

  // printer strobe flip-flop, data written is ignored
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      printer_strobe_ff <= PRINTER_STROBE_RESET;
    end else if (CE_I && io_wr_edge && hit_local) begin
      if (io_addr[1:0] == PRINTER_STROBE_SET_OFS[1:0]) begin
        printer_strobe_ff <= 1'b1; // [RULE10]
      end else if (io_addr[1:0] == PRINTER_STROBE_CLEAR_OFS[1:0]) begin
        printer_strobe_ff <= 1'b0; // [RULE10]
      end
    end
  end
  assign PRINTER_STROBE_O = printer_strobe_ff;

  // peripheral chip selects, only in i/o read or write cycles
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SCSI_CS_N_O <= 1'b1;
      SCSI_DACK_N_O <= 1'b1;
      SCSI_REG_O <= 3'h0;
      ID_OE_N_O <= 1'b1;
      COUNTER_TIMER_SEL_N_O <= 1'b1;
      COUNTER_TIMER_CHAN_O <= 2'h0;
      SERIAL_SEL_N_O <= 1'b1;
      FLOPPY_SEL_N_O <= 1'b1;
    end else if (CE_I) begin
      // unused groups match none of these and stay deselected [RULE17]
      SCSI_CS_N_O <= !((io_rd || io_wr) && hit_scsi_cs);      // [RULE11] [RULE22]
      SCSI_DACK_N_O <= !((io_rd || io_wr) && hit_scsi_dack);  // [RULE12]
      SCSI_REG_O <= io_addr[2:0];                             // [RULE11]
      ID_OE_N_O <= !(io_rd && hit_id);                        // [RULE13]
      COUNTER_TIMER_SEL_N_O <= !((io_rd || io_wr) && hit_counter_timer); // [RULE14]
      COUNTER_TIMER_CHAN_O <= io_addr[CHAN_LSB+1:CHAN_LSB];             // [RULE14]
      SERIAL_SEL_N_O <= !((io_rd || io_wr) && hit_serial);    // [RULE15]
      FLOPPY_SEL_N_O <= !((io_rd || io_wr) && hit_floppy);    // [RULE16]
    end
  end

  // jumper id buffer drives the data bus on reads only
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      DATA_O <= 8'h00;
      DATA_OE_O <= 1'b0;
    end else if (CE_I) begin
      DATA_O <= JUMPER_ID_I;
      DATA_OE_O <= io_rd && hit_id; // [RULE13]
    end
  end

  // interrupt daisy chain: counter-timer first, serial next, then expansion
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      COUNTER_TIMER_IEI_O <= 1'b1;
      SERIAL_IEI_O <= 1'b0;
      EXP_IEI_O <= 1'b0;
    end else if (CE_I) begin
      COUNTER_TIMER_IEI_O <= 1'b1;   // head of chain always enabled
      SERIAL_IEI_O <= COUNTER_TIMER_IEO_I; // [RULE4]
      EXP_IEI_O <= SERIAL_IEO_I;     // [RULE4]
    end
  end

  // memory selects
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      EPROM_SEL_N_O <= 1'b1;
      RAM_SEL_N_O <= 1'b1;
    end else if (CE_I) begin
      EPROM_SEL_N_O <= !rom_hit;     // [RULE7]
      RAM_SEL_N_O <= !ram_acc;       // [RULE7] [RULE20]
    end
  end

  // dram strobes: ras on access or refresh, column mux and cas once set hold to cycle end
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RAS_N_O <= 1'b1;
      ADDR_MUX_O <= 1'b0;
      CAS_N_O <= 1'b1;
    end else if (CE_I) begin
      RAS_N_O <= !(ram_acc || rfsh_cycle);                               // [RULE5] [RULE6]
      ADDR_MUX_O <= ram_acc && !RAS_N_O
                    && (!div_count[DIV_QUARTER_BIT] || ADDR_MUX_O);      // [RULE5]
      CAS_N_O <= !(ram_acc && ADDR_MUX_O
                   && (!div_count[DIV_HALF_BIT] || !CAS_N_O));           // [RULE5]
    end
  end

  // wait-state sequencer: one processor period of stretch per eprom access
  always_comb begin
    nxt_ws = ws_ff;
    nxt_ws_cnt = ws_cnt_ff;
    nxt_wait_n = wait_n_ff;
    case (ws_ff)
      WS_IDLE: begin
        if (rom_hit) begin
          nxt_ws = WS_STRETCH;        // [RULE8]
          nxt_ws_cnt = WAIT_LOAD;
          nxt_wait_n = 1'b0;
        end
      end
      WS_STRETCH: begin
        if (ws_cnt_ff == 4'h0) begin
          nxt_ws = WS_DONE;           // exactly one wait state [RULE21]
          nxt_wait_n = 1'b1;
        end else begin
          nxt_ws_cnt = ws_cnt_ff - 4'h1;
        end
      end
      WS_DONE: begin
        if (!mem_cycle) begin
          nxt_ws = WS_IDLE;           // rearm once the cycle ends
        end
      end
      default: begin
        nxt_ws = WS_IDLE;
        nxt_wait_n = 1'b1;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ws_ff <= WS_IDLE;
      ws_cnt_ff <= 4'h0;
      wait_n_ff <= 1'b1;
    end else if (CE_I) begin
      ws_ff <= nxt_ws;
      ws_cnt_ff <= nxt_ws_cnt;
      wait_n_ff <= nxt_wait_n;        // ram never waits [RULE21]
    end
  end
  assign WAIT_N_O = wait_n_ff;

endmodule : board_glue_decoder

/* File: src/glue_pkg.sv */
// shared constants for the board glue decoder
package glue_pkg;
  // oscillator divider: one counter, stage k gives osc / 2^(k+1)
  localparam int DIV_WIDTH = 3;
  localparam int DIV_HALF_BIT = 0;      // 8 MHz stage
  localparam int DIV_QUARTER_BIT = 1;   // 4 MHz stage
  localparam int DIV_EIGHTH_BIT = 2;    // 2 MHz stage

  // timing
  localparam int CORE_PERIOD_NS = 25;
  localparam int CPU_PERIOD_NS = 250;   // one processor wait state
  localparam int EPROM_ACCESS_NS = 450;
  // one wait state is a whole processor period, rounded up to core cycles
  localparam int WAIT_CYCLES = (CPU_PERIOD_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam logic [3:0] WAIT_LOAD = 4'(WAIT_CYCLES - 1);

  // memory map
  localparam int ROM_ADDR_BIT = 15;
  localparam int EPROM_EN_BIT = 6;

  // i/o register offsets
  localparam logic [7:0] BOARD_CONTROL_LATCH_OFS = 8'h00;
  localparam logic [7:0] PRINTER_DATA_LATCH_OFS = 8'h01;
  localparam logic [7:0] PRINTER_STROBE_SET_OFS = 8'h02;
  localparam logic [7:0] PRINTER_STROBE_CLEAR_OFS = 8'h03;
  localparam logic [7:0] JUMPER_ID_INPUT_OFS = 8'h29;

  // i/o group decode: match when (addr & mask) == value
  localparam logic [7:0] LOCAL_MASK = 8'hFB;    // bit 2 ignored
  localparam logic [7:0] SCSI_CS_MASK = 8'hF8;
  localparam logic [7:0] SCSI_CS_VAL = 8'h20;
  localparam logic [7:0] SCSI_PORT_MASK = 8'hF9;
  localparam logic [7:0] SCSI_DACK_VAL = 8'h28;
  localparam logic [7:0] GROUP_MASK = 8'hC0;
  localparam logic [7:0] COUNTER_TIMER_VAL = 8'h40;
  localparam logic [7:0] DUAL_SERIAL_VAL = 8'h80;
  localparam logic [7:0] FLOPPY_VAL = 8'hC0;
  localparam int CHAN_LSB = 4;           // counter-timer channel field

  // reset values
  localparam logic [7:0] BOARD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PRINTER_DATA_RESET = 8'h00;
  localparam logic PRINTER_STROBE_RESET = 1'b0;

  // wait-state sequencer, gray coded along idle -> stretch -> done
  typedef enum logic [1:0] {
    WS_IDLE = 2'b00,
    WS_STRETCH = 2'b01,
    WS_DONE = 2'b11
  } wait_state_t;
endpackage : glue_pkg

/* File: src/stage_counter.sv */
// binary divide counter whose stages are the divided clocks
`timescale 1ns/10ps
module stage_counter #(
  parameter int WIDTH = 3
) (
  input wire logic clk_i,              // core clock
  input wire logic rst_n_i,            // async reset, active low
  input wire logic ce_i,               // clock enable
  input wire logic tick_i,             // one pulse per oscillator period
  output logic [WIDTH-1:0] count_o     // counter stages
);
  // every stage advances on the same tick, so edges stay aligned
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (ce_i && tick_i) begin
      count_o <= count_o + WIDTH'(1);
    end
  end
endmodule : stage_counter

/* File: test/board_glue_decoder_monitor.sv */
// concurrent checks on the glue decoder ports
`timescale 1ns/10ps
module glue_monitor (
  input wire logic CORE_CLK_I, RSTN_I, CE_I, // clock, reset, enable
  input wire logic [15:0] ADDR_I, // address bus
  input wire logic MREQ_N_I, IORQ_N_I, RD_N_I, WR_N_I, M1_N_I, // bus strobes
  input wire logic [7:0] JUMPER_ID_I, DATA_O, BOARD_CTRL_O, // id in, data out, latch
  input wire logic COUNTER_TIMER_IEO_I, SERIAL_IEI_O, DATA_OE_O, PRINTER_STROBE_O, // chain, drive, strobe
  input wire logic CLK_8M_O, CLK_4M_O, CLK_2M_O, WAIT_N_O, // divided clocks, wait
  input wire logic EPROM_SEL_N_O, RAM_SEL_N_O, SCSI_CS_N_O, SCSI_DACK_N_O, ID_OE_N_O, // selects
  input wire logic COUNTER_TIMER_SEL_N_O, SERIAL_SEL_N_O, FLOPPY_SEL_N_O, // group selects
  input wire logic ADDR_MUX_O, CAS_N_O, // dram column mux and strobe
  input wire logic [1:0] COUNTER_TIMER_CHAN_O, // counter-timer channel
  input wire logic [2:0] SCSI_REG_O // scsi register index
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // bus cycle kinds and the all-quiet select state
  wire io = CE_I && !IORQ_N_I && M1_N_I && (!RD_N_I || !WR_N_I);
  wire mem = CE_I && !MREQ_N_I && IORQ_N_I && (!RD_N_I || !WR_N_I);
  wire no_sel = SCSI_CS_N_O && SCSI_DACK_N_O && ID_OE_N_O && COUNTER_TIMER_SEL_N_O
    && SERIAL_SEL_N_O && FLOPPY_SEL_N_O;
  // eprom stretch: ten low cycles then release
  sequence stretch_low; !WAIT_N_O [*8] ##1 !WAIT_N_O [*2]; endsequence
  sequence stretch_end; stretch_low ##1 WAIT_N_O; endsequence
  timer_select_a: assert property (io && ADDR_I[7:6] == 2'h1
    |=> !COUNTER_TIMER_SEL_N_O && COUNTER_TIMER_CHAN_O == $past(ADDR_I[5:4]))
    else $error("counter-timer select or channel wrong");
  serial_select_a: assert property (io && ADDR_I[7:6] == 2'h2 |=> !SERIAL_SEL_N_O)
    else $error("serial select missing");
  floppy_select_a: assert property (io && ADDR_I[7:6] == 2'h3 |=> !FLOPPY_SEL_N_O)
    else $error("floppy select missing");
  scsi_select_a: assert property (io && ADDR_I[7:3] == 5'h04 |=> !SCSI_CS_N_O && SCSI_REG_O == $past(ADDR_I[2:0]))
    else $error("scsi select or index wrong");
  dma_ack_a: assert property (io && (ADDR_I[7:0] & 8'hF9) == 8'h28 |=> !SCSI_DACK_N_O)
    else $error("dma acknowledge missing");
  id_read_a: assert property (io && !RD_N_I && (ADDR_I[7:0] & 8'hF9) == 8'h29
    |=> !ID_OE_N_O && DATA_OE_O && DATA_O == $past(JUMPER_ID_I)) else $error("id read wrong");
  unused_group_a: assert property (io && (ADDR_I[7:3] == 5'h01 || ADDR_I[7:4] == 4'h1 || ADDR_I[7:4] == 4'h3)
    |=> no_sel) else $error("select in unused group");
  io_only_a: assert property (CE_I && (IORQ_N_I || !M1_N_I) |=> no_sel)
    else $error("select outside io cycle");
  eprom_map_a: assert property (mem && !ADDR_I[15] && !BOARD_CTRL_O[6] |=> !EPROM_SEL_N_O && RAM_SEL_N_O)
    else $error("eprom not selected");
  ram_map_a: assert property (mem && (ADDR_I[15] || BOARD_CTRL_O[6]) |=> EPROM_SEL_N_O && !RAM_SEL_N_O)
    else $error("ram not selected");
  eprom_wait_a: assert property ($fell(EPROM_SEL_N_O) |-> stretch_end)
    else $error("eprom wait length wrong");
  ram_nowait_a: assert property (!RAM_SEL_N_O |-> WAIT_N_O)
    else $error("wait during ram access");
  strobe_set_a: assert property (io && !WR_N_I && (ADDR_I[7:0] & 8'hFB) == 8'h02 |=> PRINTER_STROBE_O)
    else $error("strobe not set");
  strobe_clear_a: assert property (io && !WR_N_I && (ADDR_I[7:0] & 8'hFB) == 8'h03 |=> !PRINTER_STROBE_O)
    else $error("strobe not cleared");
  eighth_phase_a: assert property ($rose(CLK_2M_O) |-> !CLK_4M_O && !CLK_8M_O)
    else $error("eighth clock misaligned");
  quarter_phase_a: assert property ($rose(CLK_4M_O) |-> !CLK_8M_O)
    else $error("quarter clock misaligned");
  chain_pass_a: assert property (CE_I |=> SERIAL_IEI_O == $past(COUNTER_TIMER_IEO_I))
    else $error("enable chain not passed");
  column_strobe_a: assert property ((!CAS_N_O || ADDR_MUX_O) |-> ADDR_MUX_O && !RAM_SEL_N_O)
    else $error("column strobe outside ram access");
endmodule : glue_monitor
bind board_glue_decoder glue_monitor glue_monitor_i (.CORE_CLK_I, .RSTN_I, .CE_I, .ADDR_I, .MREQ_N_I, .IORQ_N_I,
  .RD_N_I, .WR_N_I, .M1_N_I, .JUMPER_ID_I, .DATA_O, .BOARD_CTRL_O, .COUNTER_TIMER_IEO_I, .SERIAL_IEI_O,
  .DATA_OE_O, .PRINTER_STROBE_O, .CLK_8M_O, .CLK_4M_O, .CLK_2M_O, .WAIT_N_O, .EPROM_SEL_N_O, .RAM_SEL_N_O,
  .SCSI_CS_N_O, .SCSI_DACK_N_O, .ID_OE_N_O, .COUNTER_TIMER_SEL_N_O, .SERIAL_SEL_N_O, .FLOPPY_SEL_N_O,
  .SCSI_REG_O, .ADDR_MUX_O, .CAS_N_O, .COUNTER_TIMER_CHAN_O);

/* File: test/irq_chain_model.sv */
// peripheral model on the interrupt enable chain
`timescale 1ns/10ps
module irq_chain_model (
  input wire logic iei_i,  // enable from higher priority
  input wire logic pend_i, // request pending here
  output logic ieo_o,      // enable to lower priority
  output logic req_o       // request, only while enabled
);
  // hold lower devices off while pending, act only when enabled
  assign ieo_o = iei_i && !pend_i;
  assign req_o = iei_i && pend_i;
endmodule : irq_chain_model

/* File: test/board_glue_decoder_tb.sv */
// self-checking bench for the board glue decoder
`timescale 1ns/10ps
module board_glue_decoder_tb;
  import glue_pkg::*;
  typedef struct packed {logic [2:0] k; logic [7:0] a; logic [5:0] e;} row_t;
  logic clk = 0, rstn = 0, ce = 1, osc = 0, mreq_n = 1, iorq_n = 1, rd_n = 1, wr_n = 1, m1_n = 1, rfsh_n = 1;
  logic [15:0] addr = 16'h0000;
  logic [7:0] data = 8'h00, jid = 8'h3C, dout, bctl, pdat, s_dout;
  logic pend_a = 0, pend_b = 0, ieo_a, ieo_b, c8, c4, c2, doe, ep_n, ram_n, wt_n, ras_n, cas_n, stb;
  logic iei_a, iei_b, iei_x, scs_n, dack_n, idoe_n, tmr_n, ser_n, flp_n, s_doe, s_ep, s_ram, cas_seen, ras_seen;
  logic req_a, req_b;
  logic [5:0] s_sel;
  int waits, fails = 0, n_tests = 0, r8 = 0, r4 = 0, r2 = 0, oph = 0;
  // kind 0 io read, 1 io write, 2 memory read, 3 acknowledge, 4 refresh; selects cs, dack, id, timer, serial, floppy
  row_t rows[18] = '{'{3'h0, 8'h20, 6'h1F}, '{3'h1, 8'h27, 6'h1F}, '{3'h1, 8'h2E, 6'h2F}, '{3'h0, 8'h28, 6'h2F},
    '{3'h0, 8'h29, 6'h37}, '{3'h0, 8'h2F, 6'h37}, '{3'h1, 8'h29, 6'h3F}, '{3'h0, 8'h40, 6'h3B},
    '{3'h1, 8'h7F, 6'h3B}, '{3'h0, 8'h84, 6'h3D}, '{3'h1, 8'hBC, 6'h3D}, '{3'h0, 8'hC7, 6'h3E},
    '{3'h1, 8'hC0, 6'h3E}, '{3'h0, 8'h0C, 6'h3F}, '{3'h1, 8'h1A, 6'h3F}, '{3'h0, 8'h35, 6'h3F},
    '{3'h2, 8'h40, 6'h3F}, '{3'h3, 8'h84, 6'h3F}};
  // core clock, oscillator and divided clock edge counters
  always #12.5 clk = ~clk;
  // two oscillator rises every five core clocks, changed off the sampling edge
  always @(negedge clk) begin
    oph <= (oph == 4) ? 0 : oph + 1;
    osc <= (oph == 0 || oph == 2);
  end
  always @(posedge c8) r8++;
  always @(posedge c4) r4++;
  always @(posedge c2) r2++;
  board_glue_decoder board_glue_decoder_i (.CORE_CLK_I(clk), .RSTN_I(rstn), .CE_I(ce), .OSC_16M_I(osc),
    .ADDR_I(addr), .DATA_I(data), .MREQ_N_I(mreq_n), .IORQ_N_I(iorq_n), .RD_N_I(rd_n), .WR_N_I(wr_n),
    .M1_N_I(m1_n), .RFSH_N_I(rfsh_n), .JUMPER_ID_I(jid), .COUNTER_TIMER_IEO_I(ieo_a), .SERIAL_IEO_I(ieo_b),
    .CLK_8M_O(c8), .CLK_4M_O(c4), .CLK_2M_O(c2), .DATA_O(dout), .DATA_OE_O(doe), .EPROM_SEL_N_O(ep_n),
    .RAM_SEL_N_O(ram_n), .WAIT_N_O(wt_n), .RAS_N_O(ras_n), .CAS_N_O(cas_n), .ADDR_MUX_O(),
    .BOARD_CTRL_O(bctl), .PRINTER_DATA_O(pdat), .PRINTER_STROBE_O(stb), .SCSI_CS_N_O(scs_n),
    .SCSI_DACK_N_O(dack_n), .SCSI_REG_O(), .ID_OE_N_O(idoe_n), .COUNTER_TIMER_SEL_N_O(tmr_n),
    .COUNTER_TIMER_CHAN_O(), .SERIAL_SEL_N_O(ser_n), .FLOPPY_SEL_N_O(flp_n), .COUNTER_TIMER_IEI_O(iei_a),
    .SERIAL_IEI_O(iei_b), .EXP_IEI_O(iei_x));
  irq_chain_model timer_chain_i (.iei_i(iei_a), .pend_i(pend_a), .ieo_o(ieo_a), .req_o(req_a));
  irq_chain_model serial_chain_i (.iei_i(iei_b), .pend_i(pend_b), .ieo_o(ieo_b), .req_o(req_b));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  // one bus cycle held for n clocks, first response captured, wait and strobes watched
  task automatic cyc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d, input int n);
    @(negedge clk);
    addr = a;
    data = d;
    iorq_n = !(k < 2 || k == 3);
    mreq_n = !(k == 2 || k == 4);
    rfsh_n = (k != 4);
    m1_n = (k != 3);
    rd_n = !(k == 0 || k == 2 || k == 3); // acknowledge with read low tempts the decode
    wr_n = (k != 1);
    waits = 0;
    cas_seen = 0;
    ras_seen = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (i == 0) begin
        s_sel = {scs_n, dack_n, idoe_n, tmr_n, ser_n, flp_n};
        {s_dout, s_doe, s_ep, s_ram} = {dout, doe, ep_n, ram_n};
      end
      waits += !wt_n;
      cas_seen |= !cas_n;
      ras_seen |= !ras_n;
    end
    {iorq_n, mreq_n, rfsh_n, m1_n, rd_n, wr_n} = 6'h3F;
    @(negedge clk);
  endtask : cyc
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(negedge clk);
    check(bctl, BOARD_CONTROL_RESET, "latch reset");
    check({stb, ep_n, wt_n, iei_a}, 4'h7, "reset levels");
    rstn = 1;
    foreach (rows[j]) begin
      cyc(rows[j].k, {8'h80, rows[j].a}, 8'h00, 2);
      check(s_sel, rows[j].e, "select decode");
    end
    $display("test decode done");
    {r8, r4, r2} = {32'd0, 32'd0, 32'd0};
    repeat (400) @(negedge clk);
    check(r8 inside {[79:81]}, 1, "half rate");
    check(r4 inside {[39:41]}, 1, "quarter rate");
    check(r2 inside {[19:21]}, 1, "eighth rate");
    cyc(2, 16'h1234, 8'h00, 14);
    check({s_ep, s_ram, 8'(waits)}, {2'h1, 8'h0A}, "eprom cycle");
    cyc(2, 16'h9234, 8'h00, 14);
    check({s_ep, s_ram, 8'(waits), cas_seen}, {2'h2, 8'h00, 1'b1}, "ram cycle");
    cyc(4, 16'h007F, 8'h00, 6);
    check({ras_seen, cas_seen}, 2'h2, "refresh cycle");
    cyc(1, 16'h0004, 8'h40, 2);
    check(bctl, 8'h40, "latch alias write");
    cyc(2, 16'h1234, 8'h00, 4);
    check({s_ep, s_ram, 8'(waits)}, {2'h2, 8'h00}, "eprom unmapped");
    $display("test memory done");
    cyc(1, 16'h0005, 8'hA5, 2);
    check(pdat, 8'hA5, "printer data");
    cyc(1, 16'h0006, 8'h00, 2);
    check(stb, 1'b1, "strobe set");
    cyc(1, 16'h0007, 8'hFF, 2);
    check(stb, 1'b0, "strobe clear");
    ce = 0;
    cyc(1, 16'h0002, 8'h00, 2);
    check(stb, 1'b0, "frozen write");
    ce = 1;
    cyc(0, 16'h002D, 8'h00, 2);
    check({s_doe, s_dout}, {1'b1, jid}, "id read");
    {pend_a, pend_b} = 2'h3;
    repeat (3) @(negedge clk);
    check({iei_a, iei_b, iei_x, req_a, req_b}, 5'h12, "chain blocked at head");
    pend_a = 0;
    repeat (3) @(negedge clk);
    check({iei_a, iei_b, iei_x, req_a, req_b}, 5'h19, "chain blocked at tail");
    pend_b = 0;
    repeat (3) @(negedge clk);
    check({iei_a, iei_b, iei_x, req_a, req_b}, 5'h1C, "chain open");
    rstn = 0;
    @(negedge clk);
    check(bctl, 8'h00, "latch cleared by reset");
    rstn = 1;
    $display("test ports done");
    repeat (2) @(negedge clk);
    summarize();
  end
  // watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("[FAIL] %0t run limit reached", $time);
    summarize();
  end
endmodule : board_glue_decoder_tb
